/* File: hdl/cscirq_pkg.sv */
// package: offsets, field positions and reset values of the status-change irq
`default_nettype none
package cscirq_pkg;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CONFIG_OFFSET = 8'h05;
    localparam logic [7:0] CONTROL_OFFSET = 8'h03;
    localparam logic [7:0] GLOBAL_OFFSET = 8'h1E;
    localparam logic [7:0] DIAG_OFFSET = 8'h93;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] GLOBAL_RESET = 8'h00;
    localparam logic [7:0] DIAG_RESET = 8'h00;
    // status bit positions
    localparam int DETECT_BIT = 3;
    localparam int READY_BIT = 2;
    localparam int BATLOW_BIT = 1;
    localparam int BATTERY_DEAD_FLAG_BIT = 0;
    // control, global, diag and config register fields
    localparam int RING_EN_BIT = 7;
    localparam int CARD_KIND_BIT = 5;
    localparam int PCI_ROUTE_BIT = 4;
    localparam int CLEAR_MODE_BIT = 2;
    localparam int DIAG_PCI_BIT = 5;
    localparam int SEL_LSB = 4;
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_SMI = 4'h2;
endpackage : cscirq_pkg
`default_nettype wire

/* File: hdl/cscirq_top.sv */
// card status-change detection, masking and host interrupt routing
// Behaviour
// [RULE1] masked-off flags always read zero
// [RULE2] enabled active flag raises host interrupt
// [RULE3] clear on read or by writing one
// [RULE4] clear mode follows global control bit 2
// [RULE5] host reads status, clears serviced flags
// [RULE6] status bits 7 to 4 read zero
// [RULE7] bit 3 set on any detect-line change
// [RULE8] bit 2 set on ready rising edge
// [RULE9] io card: ready and battery-low read zero
// [RULE10] bit 1 set on battery-low warning
// [RULE11] bit 0 follows status-change line level
// [RULE12] ring mode: bit 0 shows ring line
// [RULE13] selector routes to legacy line or smi
// [RULE14] selector zero plus diag bit: pci
// [RULE15] selector zero, no diag: pci if route
// [RULE16] config bit 3 enables detect changes
// [RULE17] config bit 2 enables ready rising
// [RULE18] config bit 1 enables battery warning
// [RULE19] config bit 0 enables dead or card_status_change_line
// [RULE20] route bit high sends irq to pci
// [RULE21] card kind bit: 0 memory, 1 io
// [RULE22] ring enable switches bit 0 source
// [RULE23] inputs synchronised, events latched until cleared
//
// The implementer's own choice: the address-and-strobe port.
`default_nettype none
module cscirq_top
    import cscirq_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [7:0] o_rdata,
    // card socket lines, active high after pin inversion
    input wire logic i_card_detect_line_one,
    input wire logic i_card_detect_line_two,
    input wire logic i_card_ready_line,
    input wire logic i_battery_low_line,
    input wire logic i_card_status_change_line,
    input wire logic i_ring_indicate_line,
    // interrupt outputs
    output logic [15:0] o_legacy_irq,
    output logic o_system_management_irq,
    output logic o_pci_irq
);

    logic [7:0] status_r;
    logic [7:0] config_r;
    logic [7:0] control_r;
    logic [7:0] global_r;
    logic [7:0] diag_r;
    logic [7:0] rdata_r;
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [5:0] prev_r;
    logic [5:0] pins;
    logic [3:0] event_set;
    logic [3:0] enable_mask;
    logic [3:0] visible;
    logic [3:0] clear_req;
    logic [7:0] status_view;
    logic io_card;
    logic irq_req;
    logic [3:0] sel;
    logic to_pci;

    // true when the address equals a given offset; callers check the strobe
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign pins = {i_ring_indicate_line, i_card_status_change_line,
                   i_battery_low_line, i_card_ready_line,
                   i_card_detect_line_two, i_card_detect_line_one};

    // two-stage synchroniser; only the second stage feeds edge logic
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
            prev_r <= 6'h00;
        end else begin
            sync1_r <= pins; // RULE23
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign io_card = control_r[CARD_KIND_BIT]; // RULE21

    // event sources; a level source re-latches while it stays asserted
    always_comb begin
        event_set[DETECT_BIT] = (sync2_r[1:0] != prev_r[1:0]); // RULE7
        event_set[READY_BIT] = sync2_r[2] & ~prev_r[2] & ~io_card; // RULE8 RULE9
        event_set[BATLOW_BIT] = sync2_r[3] & ~io_card; // RULE10 RULE9
        if (control_r[RING_EN_BIT])
            event_set[BATTERY_DEAD_FLAG_BIT] = sync2_r[5]; // RULE12 RULE22
        else
            event_set[BATTERY_DEAD_FLAG_BIT] = sync2_r[4]; // RULE11 RULE19
    end

    assign enable_mask = config_r[3:0]; // RULE16 RULE17 RULE18 RULE19
    // io card hides ready and battery-low even if latched before the switch
    assign visible = status_r[3:0] & enable_mask
                     & ~{1'b0, io_card, io_card, 1'b0}; // RULE1 RULE9
    assign status_view = {4'h0, visible}; // RULE6

    // clear requests: read-to-clear or write-one-to-clear
    always_comb begin
        if (global_r[CLEAR_MODE_BIT]) // RULE4
            clear_req = (i_write && hit(i_addr, STATUS_OFFSET)) ?
                        i_wdata[3:0] : 4'h0; // RULE3
        else
            clear_req = (i_read && hit(i_addr, STATUS_OFFSET)) ?
                        4'hF : 4'h0; // RULE3
    end

    // sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn)
            status_r <= STATUS_RESET;
        else
            status_r <= {4'h0, (status_r[3:0] & ~clear_req) |
                         (event_set & enable_mask)}; // RULE23 RULE1
    end

    // writable registers
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            config_r <= CONFIG_RESET;
            control_r <= CONTROL_RESET;
            global_r <= GLOBAL_RESET;
            diag_r <= DIAG_RESET;
        end else if (i_write) begin
            if (hit(i_addr, CONFIG_OFFSET))
                config_r <= i_wdata;
            if (hit(i_addr, CONTROL_OFFSET))
                control_r <= i_wdata;
            if (hit(i_addr, GLOBAL_OFFSET))
                global_r <= i_wdata;
            if (hit(i_addr, DIAG_OFFSET))
                diag_r <= i_wdata;
        end
    end

    // read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_r <= 8'h00;
        end else if (i_read) begin
            case (i_addr)
                STATUS_OFFSET: rdata_r <= status_view; // RULE5
                CONFIG_OFFSET: rdata_r <= config_r;
                CONTROL_OFFSET: rdata_r <= control_r;
                GLOBAL_OFFSET: rdata_r <= global_r;
                DIAG_OFFSET: rdata_r <= diag_r;
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign o_rdata = rdata_r;

    assign irq_req = |visible; // RULE2
    assign sel = config_r[SEL_LSB +: 4];

    // pci path: route bit wins; selector zero also uses the diag bit
    always_comb begin
        if (control_r[PCI_ROUTE_BIT])
            to_pci = 1'b1; // RULE20
        else if (sel == SEL_NONE)
            to_pci = diag_r[DIAG_PCI_BIT]; // RULE14 RULE15
        else
            to_pci = 1'b0;
        if (sel == SEL_NONE && diag_r[DIAG_PCI_BIT])
            to_pci = 1'b1; // RULE14
    end

    // interrupt outputs registered so they are glitch free
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_legacy_irq <= 16'h0000;
            o_system_management_irq <= 1'b0;
            o_pci_irq <= 1'b0;
        end else begin
            o_pci_irq <= irq_req & to_pci;
            o_system_management_irq <= irq_req & ~control_r[PCI_ROUTE_BIT]
                                       & (sel == SEL_SMI); // RULE13
            o_legacy_irq <= 16'h0000;
            if (irq_req && !control_r[PCI_ROUTE_BIT] && sel != SEL_NONE
                && sel != SEL_SMI)
                o_legacy_irq[sel] <= 1'b1; // RULE13 RULE15
        end
    end

    // masked flags never show and reserved bits stay zero
    mask_zero_a: assert property ( // RULE1
        @(posedge i_clock) disable iff (!i_resetn)
        (i_read && i_addr == STATUS_OFFSET) |=>
        (o_rdata[7:4] == 4'h0 && (o_rdata[3:0] & ~$past(enable_mask)) == 4'h0))
        else $error("masked or reserved status bit read as one");

    reserved_zero_a: assert property ( // RULE6
        @(posedge i_clock) disable iff (!i_resetn)
        status_r[7:4] == 4'h0)
        else $error("reserved status bits set");

    reserved_read_a: assert property ( // RULE6
        @(posedge i_clock) disable iff (!i_resetn)
        (i_read && i_addr == STATUS_OFFSET) |=> o_rdata[7:4] == 4'h0)
        else $error("reserved status bits read as one");

    // routing: the route bit overrides the selector
    irq_raise_a: assert property ( // RULE20
        @(posedge i_clock) disable iff (!i_resetn)
        (irq_req && control_r[PCI_ROUTE_BIT]) |=> o_pci_irq)
        else $error("pci interrupt missing");

    route_only_pci_a: assert property ( // RULE20
        @(posedge i_clock) disable iff (!i_resetn)
        control_r[PCI_ROUTE_BIT] |=>
        (!o_system_management_irq && o_legacy_irq == 16'h0000))
        else $error("route bit did not silence legacy lines");

    detect_set_a: assert property ( // RULE7
        @(posedge i_clock) disable iff (!i_resetn)
        (event_set[DETECT_BIT] && enable_mask[DETECT_BIT]) |=>
        status_r[DETECT_BIT])
        else $error("detect change not latched");

    ready_io_a: assert property ( // RULE9
        @(posedge i_clock) disable iff (!i_resetn)
        io_card |-> !event_set[READY_BIT] && !event_set[BATLOW_BIT])
        else $error("io card set ready or battery flag");

    // flags latched as a memory card must not leak once switched to io
    io_read_a: assert property ( // RULE9
        @(posedge i_clock) disable iff (!i_resetn)
        (io_card && i_read && i_addr == STATUS_OFFSET) |=>
        o_rdata[2:1] == 2'b00)
        else $error("io card read ready or battery flag");

    read_clear_a: assert property ( // RULE3
        @(posedge i_clock) disable iff (!i_resetn)
        (i_read && i_addr == STATUS_OFFSET && !global_r[CLEAR_MODE_BIT]
         && !i_write && event_set == 4'h0) |=> status_r[3:0] == 4'h0)
        else $error("read did not clear flags");

    w1c_clear_a: assert property ( // RULE3
        @(posedge i_clock) disable iff (!i_resetn)
        (i_write && i_addr == STATUS_OFFSET && global_r[CLEAR_MODE_BIT]
         && event_set == 4'h0) |=>
        (status_r[3:0] & $past(i_wdata[3:0])) == 4'h0)
        else $error("write of one did not clear flag");

    // in write-one mode a read must leave every flag in place
    w1c_keep_a: assert property ( // RULE4
        @(posedge i_clock) disable iff (!i_resetn)
        (global_r[CLEAR_MODE_BIT] && !(i_write && i_addr == STATUS_OFFSET))
        |=> (status_r[3:0] & $past(status_r[3:0])) == $past(status_r[3:0]))
        else $error("flag lost without a clearing write");

    read_keep_a: assert property ( // RULE4
        @(posedge i_clock) disable iff (!i_resetn)
        (!global_r[CLEAR_MODE_BIT] && !(i_read && i_addr == STATUS_OFFSET))
        |=> (status_r[3:0] & $past(status_r[3:0])) == $past(status_r[3:0]))
        else $error("flag lost without a status read");

    // a set and a clear in one cycle leave the flag set
    set_wins_a: assert property ( // RULE23
        @(posedge i_clock) disable iff (!i_resetn)
        (event_set[DETECT_BIT] && enable_mask[DETECT_BIT]
         && clear_req[DETECT_BIT]) |=> status_r[DETECT_BIT])
        else $error("clear beat a new detect event");

    // pins reach the edge logic two cycles late; needs quiet pins in reset
    sync_delay_a: assert property ( // RULE23
        @(posedge i_clock) disable iff (!i_resetn)
        1'b1 |-> sync2_r == $past(pins, 2))
        else $error("synchroniser delay wrong");

    ready_rise_a: assert property ( // RULE8
        @(posedge i_clock) disable iff (!i_resetn)
        (event_set[READY_BIT] && enable_mask[READY_BIT]) |=>
        status_r[READY_BIT])
        else $error("ready rising edge not latched");

    // a ready line that just stays high must not raise the flag
    ready_level_a: assert property ( // RULE8
        @(posedge i_clock) disable iff (!i_resetn)
        (prev_r[2] && !status_r[READY_BIT]) |=> !status_r[READY_BIT])
        else $error("ready level set the flag");

    batlow_set_a: assert property ( // RULE10
        @(posedge i_clock) disable iff (!i_resetn)
        (sync2_r[3] && !io_card && enable_mask[BATLOW_BIT]) |=>
        status_r[BATLOW_BIT])
        else $error("battery warning not latched");

    dead_set_a: assert property ( // RULE11
        @(posedge i_clock) disable iff (!i_resetn)
        (!control_r[RING_EN_BIT] && sync2_r[4] && enable_mask[BATTERY_DEAD_FLAG_BIT])
        |=> status_r[BATTERY_DEAD_FLAG_BIT])
        else $error("status-change line not latched");

    ring_set_a: assert property ( // RULE12
        @(posedge i_clock) disable iff (!i_resetn)
        (control_r[RING_EN_BIT] && sync2_r[5] && enable_mask[BATTERY_DEAD_FLAG_BIT])
        |=> status_r[BATTERY_DEAD_FLAG_BIT])
        else $error("ring line not latched");

    // masked sources are dropped, not stored for later
    detect_mask_a: assert property ( // RULE16
        @(posedge i_clock) disable iff (!i_resetn)
        (!enable_mask[DETECT_BIT] && !status_r[DETECT_BIT]) |=>
        !status_r[DETECT_BIT])
        else $error("masked detect change latched");

    ready_mask_a: assert property ( // RULE17
        @(posedge i_clock) disable iff (!i_resetn)
        (!enable_mask[READY_BIT] && !status_r[READY_BIT]) |=>
        !status_r[READY_BIT])
        else $error("masked ready edge latched");

    batlow_mask_a: assert property ( // RULE18
        @(posedge i_clock) disable iff (!i_resetn)
        (!enable_mask[BATLOW_BIT] && !status_r[BATLOW_BIT]) |=>
        !status_r[BATLOW_BIT])
        else $error("masked battery warning latched");

    dead_mask_a: assert property ( // RULE19
        @(posedge i_clock) disable iff (!i_resetn)
        (!enable_mask[BATTERY_DEAD_FLAG_BIT] && !status_r[BATTERY_DEAD_FLAG_BIT]) |=>
        !status_r[BATTERY_DEAD_FLAG_BIT])
        else $error("masked battery dead latched");

    // any routed request shows up on exactly one kind of output
    irq_level_a: assert property ( // RULE2
        @(posedge i_clock) disable iff (!i_resetn)
        (irq_req && (control_r[PCI_ROUTE_BIT] || sel != SEL_NONE
         || diag_r[DIAG_PCI_BIT])) |=>
        (o_pci_irq || o_system_management_irq || o_legacy_irq != 16'h0000))
        else $error("enabled flag raised no interrupt");

    irq_quiet_a: assert property ( // RULE2
        @(posedge i_clock) disable iff (!i_resetn)
        !irq_req |=> (!o_pci_irq && !o_system_management_irq
        && o_legacy_irq == 16'h0000))
        else $error("interrupt without an enabled flag");

    smi_route_a: assert property ( // RULE13
        @(posedge i_clock) disable iff (!i_resetn)
        (irq_req && sel == SEL_SMI && !control_r[PCI_ROUTE_BIT]) |=>
        o_system_management_irq && o_legacy_irq == 16'h0000)
        else $error("smi routing wrong");

    legacy_route_a: assert property ( // RULE13
        @(posedge i_clock) disable iff (!i_resetn)
        (irq_req && !control_r[PCI_ROUTE_BIT] && sel != SEL_NONE
         && sel != SEL_SMI) |=>
        (o_legacy_irq == (16'h0001 << $past(sel)) && !o_pci_irq))
        else $error("legacy line routing wrong");

    one_line_a: assert property ( // RULE13
        @(posedge i_clock) disable iff (!i_resetn)
        $onehot0(o_legacy_irq))
        else $error("more than one legacy line driven");

    smi_excl_a: assert property ( // RULE13
        @(posedge i_clock) disable iff (!i_resetn)
        o_system_management_irq |-> (!o_pci_irq
        && o_legacy_irq == 16'h0000))
        else $error("smi shared with another output");

    diag_pci_a: assert property ( // RULE14
        @(posedge i_clock) disable iff (!i_resetn)
        (irq_req && sel == SEL_NONE && diag_r[DIAG_PCI_BIT]) |=>
        o_pci_irq && o_legacy_irq == 16'h0000)
        else $error("diag pci routing wrong");

    // selector zero without the diag bit: silent unless routed
    pci_gate_a: assert property ( // RULE15
        @(posedge i_clock) disable iff (!i_resetn)
        (sel == SEL_NONE && !diag_r[DIAG_PCI_BIT]
         && !control_r[PCI_ROUTE_BIT]) |=>
        (!o_pci_irq && !o_system_management_irq
         && o_legacy_irq == 16'h0000))
        else $error("selector zero still drove an output");

    // read data stand only in the cycle after a read strobe
    rdata_idle_a: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        !i_read |=> o_rdata == 8'h00)
        else $error("read data without a read strobe");

endmodule // cscirq_top
`default_nettype wire

/* File: testbench/cscirq_card_model.sv */
// card socket model: holds the card line levels the bench asks for
`default_nettype none
module cscirq_card_model (
    // clock
    input wire logic i_clock,
    // card lines: ring, status change, battery low, ready, detect two, one
    output var logic [5:0] o_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] lines_nxt = 6'h00;
    // lines move just after an edge, as a card settling between samples
    always @(posedge i_clock) begin
        o_lines <= lines_nxt;
    end
    task automatic set_lines(input logic [5:0] v);
        lines_nxt = v;
    endtask
endmodule // cscirq_card_model
`default_nettype wire

/* File: testbench/tb_cscirq_top.sv */
// bench: register access, card events, flag clearing and irq routing
`default_nettype none
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin \
    num_errors++; $display("mismatch at %0t: %s", $time, m); end end
module tb_cscirq_top;
    import cscirq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_write = 1'b0;
    logic i_read = 1'b0;
    logic [7:0] o_rdata;
    logic [5:0] lines;
    logic [5:0] cur = 6'h00;
    logic [15:0] o_legacy_irq;
    logic o_system_management_irq;
    logic o_pci_irq;
    int num_errors = 0;
    int checks_done = 0;
    always #10 i_clock = ~i_clock;
    cscirq_card_model i_card (.i_clock(i_clock), .o_lines(lines));
    cscirq_top i_dut (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
        .i_read(i_read), .o_rdata(o_rdata),
        .i_card_detect_line_one(lines[0]),
        .i_card_detect_line_two(lines[1]), .i_card_ready_line(lines[2]),
        .i_battery_low_line(lines[3]),
        .i_card_status_change_line(lines[4]),
        .i_ring_indicate_line(lines[5]), .o_legacy_irq(o_legacy_irq),
        .o_system_management_irq(o_system_management_irq),
        .o_pci_irq(o_pci_irq));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1 `CHK(o_rdata, e, "read data")
    endtask
    // two sync flops, latch and irq register fit well inside six cycles
    task automatic ev(input logic [5:0] v);
        cur = v;
        i_card.set_lines(v);
        repeat (6) @(posedge i_clock);
    endtask
    task automatic irq(input logic [17:0] e);
        #1 `CHK({o_legacy_irq, o_system_management_irq, o_pci_irq}, e,
            "irq outputs")
    endtask
    // toggles a detect line under one routing setup, then clears by read
    task automatic route_case(input logic [7:0] cfg, input logic [7:0] ctl,
        input logic [7:0] dg, input logic [17:0] e);
        wr(DIAG_OFFSET, dg);
        wr(CONTROL_OFFSET, ctl);
        wr(CONFIG_OFFSET, cfg);
        ev(cur ^ 6'h01);
        irq(e);
        rd(STATUS_OFFSET, 8'h08);
        repeat (2) @(posedge i_clock);
        irq(18'h00000);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_flags;
        rd(STATUS_OFFSET, STATUS_RESET);
        rd(CONFIG_OFFSET, CONFIG_RESET);
        rd(8'h7F, 8'h00);
        ev(6'h01);
        rd(STATUS_OFFSET, 8'h00);
        irq(18'h00000);
        wr(CONFIG_OFFSET, 8'h3F);
        rd(CONFIG_OFFSET, 8'h3F);
        ev(6'h03);
        irq({16'h0008, 2'b00});
        rd(STATUS_OFFSET, 8'h08);
        rd(STATUS_OFFSET, 8'h00);
        ev(6'h07);
        rd(STATUS_OFFSET, 8'h04);
        rd(STATUS_OFFSET, 8'h00);
        ev(6'h0F);
        ev(6'h07);
        rd(STATUS_OFFSET, 8'h02);
        rd(STATUS_OFFSET, 8'h00);
        $display("flag tests done");
    endtask
    // write-one-to-clear mode: reads must leave the flag alone
    task automatic t_w1c_ring;
        wr(GLOBAL_OFFSET, 8'h04);
        ev(6'h17);
        ev(6'h07);
        rd(STATUS_OFFSET, 8'h01);
        rd(STATUS_OFFSET, 8'h01);
        wr(STATUS_OFFSET, 8'h01);
        rd(STATUS_OFFSET, 8'h00);
        wr(GLOBAL_OFFSET, 8'h00);
        wr(CONTROL_OFFSET, 8'h80);
        ev(6'h27);
        ev(6'h07);
        rd(STATUS_OFFSET, 8'h01);
        rd(STATUS_OFFSET, 8'h00);
        $display("clear mode and ring tests done");
    endtask
    task automatic t_route;
        route_case(8'h2F, 8'h00, 8'h00, 18'h00002);
        route_case(8'hFF, 8'h00, 8'h00, 18'h20000);
        route_case(8'h1F, 8'h00, 8'h00, 18'h00008);
        route_case(8'h0F, 8'h00, 8'h20, 18'h00001);
        route_case(8'h0F, 8'h10, 8'h00, 18'h00001);
        route_case(8'h0F, 8'h00, 8'h00, 18'h00000);
        route_case(8'h5F, 8'h10, 8'h00, 18'h00001);
        wr(DIAG_OFFSET, 8'h00);
        wr(CONFIG_OFFSET, 8'h3F);
        // io card last: flags it hides could surface after switching back
        wr(CONTROL_OFFSET, 8'h20);
        ev(6'h03);
        ev(6'h0F);
        // detect change still counts for io cards; ready and battery hide
        rd(STATUS_OFFSET, 8'h08);
        rd(STATUS_OFFSET, 8'h00);
        $display("routing and io card tests done");
    endtask
    initial begin
        repeat (20) @(posedge i_clock);
        i_resetn <= 1'b1;
        t_flags();
        t_w1c_ring();
        t_route();
        tally_and_finish();
    end
    // watchdog sized well above the few hundred register cycles used
    initial begin
        repeat (5000) @(posedge i_clock);
        num_errors++;
        tally_and_finish();
    end
endmodule // tb_cscirq_top
`default_nettype wire
